// File: hdl/nibble_link_port.sv
// Nibble link port: transmit and receive ends of one link
`timescale 1ns/1ps
// How it works
// - port active two core cycles after enable
// - receiver drops acknowledge only when nearly full
// - transmitter checks acknowledge on first nibble only
// - nibbles after the first launched on the same clock edge as rising strobe; first nibble on word load
// - receiver captures nibble on falling strobe edge
// - stalled transmitter resumes after acknowledge returns high
// - reset map assigns buffer n to port n
// - strobe ratio one, half, third or quarter
module nibble_link_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic portEnable,
    input wire logic txMode,
    input wire nlp_pkg::nlp_rate_e strobeRate,
    input wire logic [nlp_pkg::NUM_BUFFERS*nlp_pkg::MAP_W-1:0] mapWrite,
    input wire logic mapWriteEn,
    output logic [nlp_pkg::NUM_BUFFERS*nlp_pkg::MAP_W-1:0] bufferToPortMap,
    output logic portActive,
    // Transmit words
    input wire logic txValid,
    input wire logic [nlp_pkg::WORD_W-1:0] txWord,
    output logic txReady,
    // Receive words
    output logic rxValid,
    output logic [nlp_pkg::WORD_W-1:0] rxWord,
    input wire logic rxAlmostFull,
    // Link pins
    input wire nlp_pkg::nlp_pins_in_s pinsIn,
    output nlp_pkg::nlp_pins_out_s pinsOut
);
    import nlp_pkg::*;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_HIGH = 4'h2,
        TX_LOW = 4'h4,
        TX_STALL = 4'h8
    } nlp_tx_e;

    logic [ENABLE_LATENCY-1:0] enPipe_q;
    logic [RATE_CNT_W-1:0] divCnt_q;
    logic divTick;
    nlp_tx_e txState_q;
    logic [WORD_W-1:0] txShift_q;
    logic [NIB_CNT_W-1:0] txCnt_q;
    logic strobeOut_q;
    logic [WORD_W-1:0] rxShift_q;
    logic [NIB_CNT_W-1:0] rxCnt_q;
    logic ackOut_q;
    logic strobeSync;
    logic strobePrev_q;
    logic [NIBBLE_W-1:0] nibSync;
    logic ackSync;
    logic rxFall;
    logic rxRise;
    logic txLoad;
    logic txLaunch;
    nlp_map_t mapEntry_q [NUM_BUFFERS];

    // ==========================================
    // Pin synchronisers
    nlp_sync #(.W(NIBBLE_W + 2)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn({pinsIn.strobe, pinsIn.nibble, pinsIn.ack}),
        .syncOut({strobeSync, nibSync, ackSync})
    );

    // ==========================================
    // Enable latency
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enPipe_q <= '0;
        end else begin
            enPipe_q <= {enPipe_q[ENABLE_LATENCY-2:0], portEnable};
        end
    end
    assign portActive = enPipe_q[ENABLE_LATENCY-1] & portEnable;

    // ==========================================
    // Buffer-to-port map
    for (genvar g = 0; g < NUM_BUFFERS; g++) begin : g_map
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                mapEntry_q[g] <= MAP_W'(g);
            end else if (mapWriteEn) begin
                mapEntry_q[g] <= mapWrite[g*MAP_W +: MAP_W];
            end
        end
        assign bufferToPortMap[g*MAP_W +: MAP_W] = mapEntry_q[g];
    end

    // ==========================================
    // Strobe rate divider
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_q <= '0;
        end else if (divTick) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_q + 2'h1;
        end
    end
    assign divTick = (divCnt_q == RATE_CNT_W'(strobeRate));

    // ==========================================
    // Transmitter
    assign txReady = portActive & txMode & (txState_q == TX_IDLE);
    assign txLoad = divTick & txReady & txValid;
    assign txLaunch = divTick & portActive & txMode
        & (txState_q == TX_LOW) & (txCnt_q != '0);

    // ==========================================
    // Transmit shift register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txShift_q <= '0;
        end else if (txLoad) begin
            txShift_q <= txWord;
        end else if (txLaunch) begin
            txShift_q <= {txShift_q[WORD_W-NIBBLE_W-1:0], 4'h0};
        end
    end

    // ==========================================
    // Transmit state machine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txState_q <= TX_IDLE;
            txCnt_q <= '0;
            strobeOut_q <= 1'b0;
        end else if (!(portActive && txMode)) begin
            txState_q <= TX_IDLE;
            strobeOut_q <= 1'b0;
        end else if (divTick) begin
            case (txState_q)
                TX_IDLE: begin
                    if (txValid) begin
                        txCnt_q <= '0;
                        txState_q <= TX_LOW;
                    end
                end
                TX_LOW: begin
                    if (txCnt_q == '0 && !ackSync) begin
                        txState_q <= TX_STALL;
                    end else begin
                        strobeOut_q <= 1'b1;
                        txState_q <= TX_HIGH;
                    end
                end
                TX_STALL: begin
                    if (ackSync) begin
                        strobeOut_q <= 1'b1;
                        txState_q <= TX_HIGH;
                    end
                end
                TX_HIGH: begin
                    strobeOut_q <= 1'b0;
                    if (txCnt_q == NIB_LAST) begin
                        txState_q <= TX_IDLE;
                    end else begin
                        txCnt_q <= txCnt_q + 3'h1;
                        txState_q <= TX_LOW;
                    end
                end
                default: txState_q <= TX_IDLE;
            endcase
        end
    end

    // ==========================================
    // Receiver
    assign rxFall = strobePrev_q & ~strobeSync;
    assign rxRise = ~strobePrev_q & strobeSync;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobePrev_q <= 1'b0;
            rxShift_q <= '0;
            rxCnt_q <= '0;
            rxValid <= 1'b0;
            rxWord <= '0;
        end else begin
            strobePrev_q <= strobeSync;
            rxValid <= 1'b0;
            if (!(portActive && !txMode)) begin
                rxCnt_q <= '0;
            end else if (rxFall) begin
                rxShift_q <= {rxShift_q[WORD_W-NIBBLE_W-1:0], nibSync};
                rxCnt_q <= rxCnt_q + 3'h1;
                if (rxCnt_q == NIB_LAST) begin
                    rxValid <= 1'b1;
                    rxWord <= {rxShift_q[WORD_W-NIBBLE_W-1:0], nibSync};
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ackOut_q <= 1'b1;
        end else if (rxRise && rxCnt_q == 3'h1) begin
            ackOut_q <= ~rxAlmostFull;
        end else if (!rxAlmostFull) begin
            ackOut_q <= 1'b1;
        end
    end

    // ==========================================
    // Pin drive
    always_comb begin
        pinsOut.strobe = strobeOut_q;
        pinsOut.strobeOe = portActive & txMode;
        pinsOut.nibble = txShift_q[WORD_W-1 -: NIBBLE_W];
        pinsOut.nibbleOe = portActive & txMode;
        pinsOut.ack = ackOut_q;
        pinsOut.ackOe = portActive & ~txMode;
    end
endmodule : nibble_link_port

// File: hdl/nlp_pkg.sv
// Package of constants and types for the nibble link port
package nlp_pkg;
    // ==========================================
    // Widths and counts
    localparam int NIBBLE_W = 4;
    localparam int WORD_W = 32;
    localparam int NIBBLES_PER_WORD = WORD_W / NIBBLE_W;
    localparam int NIB_CNT_W = 3;
    localparam int NUM_BUFFERS = 6;
    localparam int MAP_W = 3;
    localparam int ENABLE_LATENCY = 2;
    localparam int RATE_CNT_W = 2;
    localparam logic [NIB_CNT_W-1:0] NIB_LAST = 3'h7;
    localparam logic [1:0] RATE_RESET = 2'h1;

    // ==========================================
    // Strobe-to-core ratio codes
    typedef enum logic [1:0] {
        NLP_RATE_1 = 2'h0,
        NLP_RATE_2 = 2'h1,
        NLP_RATE_3 = 2'h2,
        NLP_RATE_4 = 2'h3
    } nlp_rate_e;

    // ==========================================
    // Link pin bundles
    typedef struct packed {
        logic strobe;
        logic [NIBBLE_W-1:0] nibble;
        logic ack;
    } nlp_pins_in_s;

    typedef struct packed {
        logic strobe;
        logic strobeOe;
        logic [NIBBLE_W-1:0] nibble;
        logic nibbleOe;
        logic ack;
        logic ackOe;
    } nlp_pins_out_s;

    typedef logic [MAP_W-1:0] nlp_map_t;
endpackage : nlp_pkg

// File: hdl/nlp_sync.sv
// Two-flop synchroniser bank for link pin inputs
`timescale 1ns/1ps
module nlp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // ==========================================
    // Synchroniser stages
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : nlp_sync

// File: tb/nlp_partner.sv
// Far-end link port model
`timescale 1ns/1ps
module nlp_partner (
    // Device pins
    input wire nlp_pkg::nlp_pins_out_s devOut,
    output nlp_pkg::nlp_pins_in_s devIn,
    // Receive side
    input wire logic holdAck,
    output logic [31:0] gotWord,
    output logic [7:0] gotCount
);
    import nlp_pkg::*;
    logic stb = 1'b0;
    logic [3:0] nib = 4'h0;
    assign devIn.strobe = devOut.strobeOe ? devOut.strobe : stb;
    assign devIn.nibble = devOut.nibbleOe ? devOut.nibble : nib;
    assign devIn.ack = devOut.ackOe ? devOut.ack : !holdAck;
    initial gotCount = 8'h0;
    always @(negedge devIn.strobe) begin
        if (devOut.strobeOe) begin
            gotWord <= {gotWord[27:0], devIn.nibble};
            gotCount <= gotCount + 8'h1;
        end
    end
    task automatic send(input logic [31:0] w);
        for (int k = 0; k < 99 && !devIn.ack; k++) #4;
        for (int i = 7; i >= 0; i--) begin
            stb = 1'b1;
            #4 nib = w[4*i+:4];
            #20 stb = 1'b0;
            #24;
        end
        nib = ~nib;
    endtask : send
endmodule : nlp_partner

// File: tb/nlp_sva.sv
// Assertion checker for the nibble link port
`timescale 1ns/1ps
module nlp_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Watched ports
    input wire logic portEnable,
    input wire logic portActive,
    input wire logic txMode,
    input wire nlp_pkg::nlp_rate_e strobeRate,
    input wire logic mapWriteEn,
    input wire logic [nlp_pkg::NUM_BUFFERS*nlp_pkg::MAP_W-1:0] mapWrite,
    input wire logic [nlp_pkg::NUM_BUFFERS*nlp_pkg::MAP_W-1:0] bufferToPortMap,
    input wire logic rxValid,
    input wire logic rxAlmostFull,
    input wire nlp_pkg::nlp_pins_out_s pinsOut
);
    import nlp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_enable_delay: assert property ($rose(portEnable) |->
        !portActive ##1 !portActive ##1 (portActive || !portEnable)) else $error("active early");
    chk_ack_cause: assert property ($fell(pinsOut.ack) |-> $past(rxAlmostFull))
        else $error("ack low without full");
    chk_nibble_hold: assert property ($past(pinsOut.strobe) |->
        $stable(pinsOut.nibble)) else $error("nibble moved with strobe high or falling");
    chk_rate_one: assert property (txMode && strobeRate == NLP_RATE_1 &&
        $rose(pinsOut.strobe) |=> !pinsOut.strobe) else $error("strobe high too long");
    chk_rate_four: assert property (txMode && strobeRate == NLP_RATE_4 &&
        $rose(pinsOut.strobe) |-> pinsOut.strobe[*4] ##1 !pinsOut.strobe) else $error("bad high");
    chk_map_write: assert property (mapWriteEn |=> bufferToPortMap == $past(mapWrite))
        else $error("map not loaded");
    chk_map_hold: assert property (!$past(mapWriteEn) |-> $stable(bufferToPortMap))
        else $error("map changed");
    chk_rx_pulse: assert property (rxValid |=> !rxValid) else $error("rx pulse long");
endmodule : nlp_sva
bind nibble_link_port nlp_sva chk (
    .clk(clk),
    .rst_b(rst_b),
    .portEnable(portEnable),
    .portActive(portActive),
    .txMode(txMode),
    .strobeRate(strobeRate),
    .mapWriteEn(mapWriteEn),
    .mapWrite(mapWrite),
    .bufferToPortMap(bufferToPortMap),
    .rxValid(rxValid),
    .rxAlmostFull(rxAlmostFull),
    .pinsOut(pinsOut)
);

// File: tb/tb.sv
// Testbench for the nibble link port
`timescale 1ns/1ps
module tb;
    import nlp_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, portEnable = 1'b0, txMode = 1'b1, mapWriteEn = 1'b0;
    logic txValid = 1'b0, rxAlmostFull = 1'b0, holdAck = 1'b0, txReady, rxValid, portActive;
    nlp_rate_e strobeRate = NLP_RATE_1;
    logic [17:0] mapWrite = 18'h0, bufferToPortMap, idMap;
    logic [31:0] txWord = 32'h0, rxWord, gotWord;
    logic [7:0] gotCount, c0;
    nlp_pins_in_s pinsIn;
    nlp_pins_out_s pinsOut;
    int nMismatch = 0, checksDone = 0, k;
    nibble_link_port dut (
        .clk(clk),
        .rst_b(rst_b),
        .portEnable(portEnable),
        .txMode(txMode),
        .strobeRate(strobeRate),
        .mapWrite(mapWrite),
        .mapWriteEn(mapWriteEn),
        .bufferToPortMap(bufferToPortMap),
        .portActive(portActive),
        .txValid(txValid),
        .txWord(txWord),
        .txReady(txReady),
        .rxValid(rxValid),
        .rxWord(rxWord),
        .rxAlmostFull(rxAlmostFull),
        .pinsIn(pinsIn),
        .pinsOut(pinsOut)
    );
    nlp_partner peer (.devOut(pinsOut), .devIn(pinsIn), .holdAck(holdAck),
        .gotWord(gotWord), .gotCount(gotCount));
    initial forever #2 clk = ~clk;
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checksDone++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", nm, e, g);
            nMismatch++;
        end
    endtask : cmp
    task automatic wrapUp();
        if (nMismatch == 0 && checksDone > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrapUp
    task automatic hang(input string nm);
        $display("unexpected %s exp done got timeout", nm);
        nMismatch++;
        wrapUp();
    endtask : hang
    task automatic tReset();
        for (int i = 0; i < 6; i++) idMap[3*i+:3] = 3'(i);
        cmp("map", 32'(idMap), 32'(bufferToPortMap));
        @(negedge clk) mapWrite = 18'h2C4D1;
        mapWriteEn = 1'b1;
        @(negedge clk) mapWriteEn = 1'b0;
        cmp("map wr", 32'h2C4D1, 32'(bufferToPortMap));
    endtask : tReset
    task automatic tEnable(input logic m);
        @(negedge clk) portEnable = 1'b0;
        @(negedge clk) txMode = m;
        @(negedge clk) portEnable = 1'b1;
        @(negedge clk) cmp("active", 0, 32'(portActive));
        @(negedge clk) cmp("active", 1, 32'(portActive));
        cmp("pin oe", 32'({m, m, !m}), 32'({pinsOut.strobeOe, pinsOut.nibbleOe, pinsOut.ackOe}));
    endtask : tEnable
    task automatic offer(input logic [31:0] w);
        c0 = gotCount;
        txWord = w;
        txValid = 1'b1;
        for (k = 0; k < 200 && txReady !== 1'b0; k++) @(negedge clk);
        if (k == 200) hang("offer");
        txValid = 1'b0;
    endtask : offer
    task automatic tTx(input nlp_rate_e r, input logic [31:0] w);
        @(negedge clk) strobeRate = r;
        offer(w);
        for (k = 0; k < 800 && gotCount !== 8'(c0 + 8); k++) @(negedge clk);
        if (k == 800) hang("tx");
        cmp("tx word", w, gotWord);
    endtask : tTx
    task automatic tStall();
        @(negedge clk) holdAck = 1'b1;
        offer(32'hA5C30F96);
        repeat (60) @(negedge clk);
        cmp("stalled", 32'(c0), 32'(gotCount));
        holdAck = 1'b0;
        for (k = 0; k < 30 && gotCount === c0; k++) @(negedge clk);
        if (k == 30) hang("resume");
        holdAck = 1'b1;
        for (k = 0; k < 300 && gotCount !== 8'(c0 + 8); k++) @(negedge clk);
        if (k == 300) hang("later nibbles");
        cmp("stall word", 32'hA5C30F96, gotWord);
        holdAck = 1'b0;
    endtask : tStall
    task automatic tRx(input logic full, input logic [31:0] w);
        @(negedge clk) rxAlmostFull = full;
        for (k = 0; k < 30 && pinsOut.ack !== 1'b1; k++) @(negedge clk);
        if (k == 30) hang("ack high");
        fork
            peer.send(w);
            begin
                for (k = 0; k < 300 && rxValid !== 1'b1; k++) @(negedge clk);
                if (k == 300) hang("rx");
                cmp("rx word", w, rxWord);
            end
        join
        cmp("ack", 32'(!full), 32'(pinsOut.ack));
    endtask : tRx
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        tReset();
        tEnable(1'b1);
        for (int r = 0; r < 4; r++) tTx(nlp_rate_e'(r), 32'h1F2E3D4C ^ r);
        tStall();
        tEnable(1'b0);
        tRx(1'b0, 32'h90ABCDE7);
        tRx(1'b1, 32'h0F1E2D3C);
        tRx(1'b0, 32'hFEDCBA98);
        wrapUp();
    end
endmodule : tb
